// File: inc/cmp_pkg.sv
// Constants and carrier types for the analog comparator control block.
// Assumes a 32-bit AHB-Lite register bus and one 20 MHz system clock.
package cmp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h18;
    localparam logic [7:0] IDX_SEL = 8'h19;
    localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADDR_SEL = {IDX_SEL, 2'b00};
    localparam int ADDR_W = 10;

    // Control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_RES_BIT = 6;
    localparam int CTRL_SMP_BIT = 5;
    localparam int CTRL_INV_BIT = 4;
    localparam int CTRL_MINUS_HI = 3;
    localparam int CTRL_MINUS_LO = 1;
    localparam int CTRL_PLUS_BIT = 0;

    // Selection register fields
    localparam int SEL_OUT_BIT = 7;
    localparam int SEL_WAKE_BIT = 6;
    localparam int SEL_RHI_BIT = 5;
    localparam int SEL_RLO_BIT = 4;
    localparam int SEL_LVL_HI = 3;
    localparam int SEL_LVL_LO = 0;

    // Minus input codes; 3'h6 and 3'h7 are reserved
    localparam logic [2:0] MINUS_PA3 = 3'h0;
    localparam logic [2:0] MINUS_PA4 = 3'h1;
    localparam logic [2:0] MINUS_BANDGAP = 3'h2;
    localparam logic [2:0] MINUS_LADDER = 3'h3;
    localparam logic [2:0] MINUS_PB6 = 3'h4;
    localparam logic [2:0] MINUS_PB7 = 3'h5;

    localparam logic [3:0] LVL_RESET = 4'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Register selected by an address phase
    typedef enum logic [2:0] {
        SEL_NONE = 3'b001,
        SEL_CTRL = 3'b010,
        SEL_SELR = 3'b100
    } reg_sel_t;

    // Control register state
    typedef struct packed {
        logic enable;
        logic sample;
        logic invert;
        logic [2:0] minus_sel;
        logic plus_pa4;
    } ctrl_reg_t;

    // Selection register state
    typedef struct packed {
        logic out_en;
        logic wake_en;
        logic range_hi;
        logic range_lo;
        logic [3:0] level;
    } sel_reg_t;

    // Port A line 0 drive
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
endpackage

// File: rtl/analog_comparator_control.sv
// Control and readout logic around the on-chip analog comparator.
// Assumes an AHB-Lite master, an asynchronous comparator output and
// an asynchronous second timer clock sampled on clk.
//
// Operation
// [R1] Control bit 7 enables comparator; cleared by reset.
// [R2] Software disables digital input on analog pins when comparator on.
// [R3] Read-only control bit 6 shows result, 1 when plus above minus.
// [R4] Control bit 5 selects timer-clock resampling of result; resets 0.
// [R5] Control bit 4 inverts result polarity; resets 0.
// [R6] Control bits 3..1 select minus input; codes 11X reserved.
// [R7] Software avoids bandgap minus input when using comparator wake-up.
// [R8] Control bit 0 selects plus input: ladder tap or port A line 4.
// [R9] Selection bit 7 drives result onto port A line 0.
// [R10] Selection bit 6 raises wake-up on each result level change.
// [R11] Selection bits 5 and 4 pick ladder high and low range.
// [R12] Selection bits 3..0 set ladder tap, 0000 lowest to 1111.
// [R13] Sampled mode registers inverted result on timer clock edge.
// [R14] Raw comparator output synchronised by two registers first.
`timescale 1ns/1ns
module analog_comparator_control
    import cmp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Analog comparator
    input wire logic cmp_raw,
    input wire logic second_timer_clock,
    output ctrl_reg_t analog_ctrl,
    output sel_reg_t ladder_ctrl,
    // Port A line 0 and wake-up
    output pin_drive_t port_a_line0,
    output logic wake_up
);

    function automatic reg_sel_t decode(input logic [31:0] addr);
        if (addr[ADDR_W-1:0] == ADDR_CTRL && addr[31:ADDR_W] == '0) begin
            return SEL_CTRL;
        end
        if (addr[ADDR_W-1:0] == ADDR_SEL && addr[31:ADDR_W] == '0) begin
            return SEL_SELR;
        end
        return SEL_NONE;
    endfunction

    ctrl_reg_t ctrl_ff;
    sel_reg_t sel_ff;
    reg_sel_t dsel_ff;
    logic wr_pend_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic raw_s1_ff, raw_s2_ff;
    logic tck_s1_ff, tck_s2_ff, tck_d_ff;
    logic sampled_ff;
    logic result_ff;
    logic prev_ff;
    logic wake_ff;
    pin_drive_t pin_ff;
    logic addr_ok;
    reg_sel_t asel;
    logic tck_edge;
    logic inv_w;
    logic nxt_result;
    logic wr_ctrl, wr_sel;

    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    assign asel = decode(haddr);
    assign wr_ctrl = wr_pend_ff && dsel_ff == SEL_CTRL;
    assign wr_sel = wr_pend_ff && dsel_ff == SEL_SELR;

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    // Address phase capture; only whole-word writes are taken
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_pend_ff <= 1'b0;
            dsel_ff <= SEL_NONE;
        end else begin
            wr_pend_ff <= addr_ok && hwrite && hsize == HSIZE_WORD;
            dsel_ff <= addr_ok ? asel : SEL_NONE;
        end
    end

    // [R3] Status readback
    // Read data is built in the address phase so hrdata is a flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hrdata_ff <= '0;
        end else if (addr_ok && !hwrite && asel == SEL_CTRL) begin
            hrdata_ff <= '0;
            hrdata_ff[CTRL_EN_BIT] <= ctrl_ff.enable;
            hrdata_ff[CTRL_RES_BIT] <= result_ff;
            hrdata_ff[CTRL_SMP_BIT] <= ctrl_ff.sample;
            hrdata_ff[CTRL_INV_BIT] <= ctrl_ff.invert;
            hrdata_ff[CTRL_MINUS_HI:CTRL_MINUS_LO] <= ctrl_ff.minus_sel;
            hrdata_ff[CTRL_PLUS_BIT] <= ctrl_ff.plus_pa4;
        end else begin
            // Selection register is write-only and reads as zero
            hrdata_ff <= '0;
        end
    end

    // [R1] Enable and control fields
    // Bit 6 is read-only; writes to it are dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_ff <= '0;
        end else if (wr_ctrl) begin
            ctrl_ff.enable <= hwdata[CTRL_EN_BIT];
            ctrl_ff.sample <= hwdata[CTRL_SMP_BIT];
            ctrl_ff.invert <= hwdata[CTRL_INV_BIT];
            // [R6] Minus select
            ctrl_ff.minus_sel <= hwdata[CTRL_MINUS_HI:CTRL_MINUS_LO];
            // [R8] Plus select
            ctrl_ff.plus_pa4 <= hwdata[CTRL_PLUS_BIT];
        end
    end

    // [R11] Range and level fields
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_ff <= '0;
            sel_ff.level <= LVL_RESET;
        end else if (wr_sel) begin
            sel_ff.out_en <= hwdata[SEL_OUT_BIT];
            sel_ff.wake_en <= hwdata[SEL_WAKE_BIT];
            sel_ff.range_hi <= hwdata[SEL_RHI_BIT];
            sel_ff.range_lo <= hwdata[SEL_RLO_BIT];
            // [R12] Ladder tap level
            sel_ff.level <= hwdata[SEL_LVL_HI:SEL_LVL_LO];
        end
    end

    // [R14] Two-stage synchroniser
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            raw_s1_ff <= 1'b0;
            raw_s2_ff <= 1'b0;
        end else begin
            raw_s1_ff <= cmp_raw;
            raw_s2_ff <= raw_s1_ff;
        end
    end

    // Timer clock is slower than clk; its rising edge is found after sync
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tck_s1_ff <= 1'b0;
            tck_s2_ff <= 1'b0;
            tck_d_ff <= 1'b0;
        end else begin
            tck_s1_ff <= second_timer_clock;
            tck_s2_ff <= tck_s1_ff;
            tck_d_ff <= tck_s2_ff;
        end
    end

    assign tck_edge = tck_s2_ff && !tck_d_ff;
    // [R5] Polarity inversion
    // A disabled comparator reads as zero before inversion
    assign inv_w = (raw_s2_ff && ctrl_ff.enable) ^ ctrl_ff.invert;

    // [R13] Timer-clock sample
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sampled_ff <= 1'b0;
        end else if (tck_edge) begin
            sampled_ff <= inv_w;
        end
    end

    // [R4] Sampled or direct path
    assign nxt_result = ctrl_ff.sample ? sampled_ff : inv_w;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            result_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            result_ff <= nxt_result;
            prev_ff <= result_ff;
        end
    end

    // [R10] Wake-up on level change
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= sel_ff.wake_en && (result_ff != prev_ff);
        end
    end

    // [R9] Drive port A line 0
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_ff <= '0;
        end else begin
            pin_ff.out <= result_ff && sel_ff.out_en;
            pin_ff.oe <= sel_ff.out_en;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
    assign analog_ctrl = ctrl_ff;
    assign ladder_ctrl = sel_ff;
    assign port_a_line0 = pin_ff;
    assign wake_up = wake_ff;

    sequence s_ctrl_write;
        wr_ctrl;
    endsequence

    sequence s_sel_write;
        wr_sel;
    endsequence

    sequence s_ctrl_read;
        addr_ok && !hwrite && asel == SEL_CTRL;
    endsequence

    sequence s_level_change;
        sel_ff.wake_en && result_ff != prev_ff;
    endsequence

    a_enable_reset: assert property (@(posedge clk) !rst_b |=> !ctrl_ff.enable) // [R1]
        else $error("enable not cleared by reset");

    a_status_read: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        s_ctrl_read |=> hrdata[CTRL_RES_BIT] == $past(result_ff))
        else $error("status bit differs from result");

    a_sample_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        (ctrl_ff.sample && !tck_edge) |=> $stable(sampled_ff) && result_ff == $past(sampled_ff))
        else $error("sampled path not held between timer edges");

    a_direct_invert: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        (ctrl_ff.enable && !ctrl_ff.sample)
        |=> result_ff == ($past(raw_s2_ff) ^ $past(ctrl_ff.invert)))
        else $error("direct result polarity wrong");

    a_minus_write: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        s_ctrl_write |=> analog_ctrl.minus_sel == $past(hwdata[CTRL_MINUS_HI:CTRL_MINUS_LO]))
        else $error("minus select not written");

    a_plus_write: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        s_ctrl_write |=> analog_ctrl.plus_pa4 == $past(hwdata[CTRL_PLUS_BIT]))
        else $error("plus select not written");

    a_pin_drive: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        sel_ff.out_en |=> port_a_line0.oe && port_a_line0.out == $past(result_ff))
        else $error("pin not driven with result");

    a_pin_release: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        !sel_ff.out_en |=> !port_a_line0.oe && !port_a_line0.out)
        else $error("pin driven while released");

    a_wake_change: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        s_level_change |=> wake_up)
        else $error("wake-up missed on change");

    a_wake_off: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        !sel_ff.wake_en |=> !wake_up)
        else $error("wake-up while disabled");

    a_range_write: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        s_sel_write |=> ladder_ctrl.range_hi == $past(hwdata[SEL_RHI_BIT])
        && ladder_ctrl.range_lo == $past(hwdata[SEL_RLO_BIT]))
        else $error("range bits not written");

    a_level_write: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        s_sel_write |=> ladder_ctrl.level == $past(hwdata[SEL_LVL_HI:SEL_LVL_LO]))
        else $error("level not written");

    a_timer_sample: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        tck_edge |=> sampled_ff == $past(inv_w))
        else $error("timer edge sample wrong");

    a_raw_sync: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        $past(rst_b) && $past(rst_b, 2) |-> raw_s2_ff == $past(cmp_raw, 2))
        else $error("synchroniser latency wrong");

endmodule // analog_comparator_control

// File: bench/comparator_far_side.sv
// Far-side model: analog pins, bandgap and reference ladder at the comparator.
// Assumes pin voltages come from the bench in arbitrary 8-bit units.
`timescale 1ns/1ns
module comparator_far_side
    import cmp_pkg::*;
(
    // Controls from the block
    input wire ctrl_reg_t analog_ctrl,
    input wire sel_reg_t ladder_ctrl,
    // Pin voltages
    input wire logic [7:0] v_pa3,
    input wire logic [7:0] v_pa4,
    input wire logic [7:0] v_pb6,
    input wire logic [7:0] v_pb7,
    // Raw comparator output
    output logic cmp_raw
);
    // Bandgap level in model units, arbitrary
    localparam logic [7:0] V_BANDGAP = 8'h78;
    logic [7:0] tap;
    logic [7:0] plus_v;
    logic [7:0] minus_v;
    assign tap = {ladder_ctrl.range_hi, ladder_ctrl.range_lo, ladder_ctrl.level, 2'h0};
    assign plus_v = analog_ctrl.plus_pa4 ? v_pa4 : tap;
    always_comb begin
        case (analog_ctrl.minus_sel)
            MINUS_PA3: minus_v = v_pa3;
            MINUS_PA4: minus_v = v_pa4;
            MINUS_BANDGAP: minus_v = V_BANDGAP;
            MINUS_LADDER: minus_v = tap;
            MINUS_PB6: minus_v = v_pb6;
            MINUS_PB7: minus_v = v_pb7;
            // Reserved codes: minus floats high, a hazard for careless software
            default: minus_v = 8'hFF;
        endcase
    end
    // Switched-off comparator output is garbage, shown high
    assign cmp_raw = analog_ctrl.enable ? (plus_v > minus_v) : 1'b1;
endmodule // comparator_far_side

// File: bench/analog_comparator_control_test.sv
// Self-checking bench for the comparator control block.
// Assumes one AHB-Lite master (this bench) and the far-side analog model.
`timescale 1ns/1ns
module analog_comparator_control_test;
    import cmp_pkg::*;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, cmp_raw, wake_up, second_timer_clock;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] v_pa3, v_pa4, v_pb6, v_pb7;
    ctrl_reg_t analog_ctrl;
    sel_reg_t ladder_ctrl;
    pin_drive_t port_a_line0;
    int err_count, total_checks, wakes, wake_base, i;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end

    analog_comparator_control u_analog_comparator_control (.clk(clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cmp_raw(cmp_raw), .second_timer_clock(second_timer_clock),
        .analog_ctrl(analog_ctrl), .ladder_ctrl(ladder_ctrl),
        .port_a_line0(port_a_line0), .wake_up(wake_up));
    comparator_far_side u_comparator_far_side (.analog_ctrl(analog_ctrl),
        .ladder_ctrl(ladder_ctrl), .v_pa3(v_pa3), .v_pa4(v_pa4), .v_pb6(v_pb6),
        .v_pb7(v_pb7), .cmp_raw(cmp_raw));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (wake_up === 1'b1) wakes++;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Control readback while disabled: result equals the invert bit
    function automatic logic [31:0] ctrl_off(input logic [31:0] v);
        return {24'h0, v[7], v[4], v[5:0]};
    endfunction

    // One single word transfer; waits out both phases on hready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One timer clock rise, high and low four system clocks each
    task automatic timer_pulse();
        @(posedge clk);
        second_timer_clock <= 1'b1;
        repeat (4) @(posedge clk);
        second_timer_clock <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        {rst_b, hsel, hwrite, second_timer_clock} = 4'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        {v_pa3, v_pa4, v_pb6, v_pb7} = 32'h6432_C8C8;
        seed = 32'h386E;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        `CHK({analog_ctrl, ladder_ctrl, port_a_line0}, 17'h0)
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        // Every minus code, reserved ones too; random invert and plus bits, sample bit clear, comparator off
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = {24'h0, 2'b00, 1'b0, seed[4], i[2:0], seed[0]};
            bus(1'b1, ADDR_CTRL, d);
            tick(5);
            `CHK(analog_ctrl, {d[7], d[5], d[4], d[3:1], d[0]})
            bus(1'b0, ADDR_CTRL, 32'h0);
            `CHK(rd, ctrl_off(d))
        end
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = {24'h0, 2'b00, seed[5:0]};
            bus(1'b1, ADDR_SEL, d);
            tick(1);
            `CHK(ladder_ctrl, d[7:0])
            bus(1'b0, ADDR_SEL, 32'h0);
            `CHK(rd, 32'h0)
        end
        bus(1'b0, 32'h68, 32'h0);
        `CHK(rd, 32'h0)
        // Pins kept analog; a pin, not the bandgap, is the wake-up minus input
        bus(1'b1, ADDR_CTRL, 32'h81);
        bus(1'b1, ADDR_SEL, 32'hC0);
        tick(6);
        wake_base = wakes;
        @(posedge clk);
        v_pa4 <= 8'h96;
        tick(7);
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'hC1)
        `CHK(port_a_line0, 2'b11)
        `CHK(wakes - wake_base, 1)
        bus(1'b1, ADDR_CTRL, 32'h91);
        tick(6);
        `CHK(port_a_line0, 2'b01)
        `CHK(wakes - wake_base, 2)
        bus(1'b1, ADDR_SEL, 32'h00);
        bus(1'b1, ADDR_CTRL, 32'h81);
        tick(6);
        `CHK(port_a_line0.oe, 1'b0)
        `CHK(wakes - wake_base, 2)
        // Ladder as plus input against port A line 3, both ends of the level range
        bus(1'b1, ADDR_CTRL, 32'h80);
        bus(1'b1, ADDR_SEL, 32'h00);
        tick(6);
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h80)
        bus(1'b1, ADDR_SEL, 32'h3F);
        tick(6);
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'hC0)
        // Timer sample starts at zero; prime it with a high result first
        timer_pulse();
        // Sampled mode holds the old result until a timer clock rise
        bus(1'b1, ADDR_CTRL, 32'hA1);
        @(posedge clk);
        v_pa4 <= 8'h32;
        tick(8);
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'hE1)
        timer_pulse();
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'hA1)
        report_and_stop();
    end
endmodule // analog_comparator_control_test
